// ---- hdl/wake_ready_params.svh ----
// Constants for the power-on wake-ready controller.
// Assumes the configuration flag word is loaded before reset release.
`ifndef WAKE_READY_PARAMS_SVH
`define WAKE_READY_PARAMS_SVH

`define FLAG_WIDTH          16
`define FLAG_SELF_POWERED   0
`define FLAG_PIN_SEL_BIT    12
`define FLAG_POLARITY_BIT   13
`define FLAG_OUT_TYPE_BIT   14
`define FLAG_INDICATION_BIT 15
`define FLAG_EVENT_HI       15
`define FLAG_EVENT_LO       12
`define FLAG_EVENT_ENABLE   4'h7
`define EVENT_PULSE_NS      1000
`define CLK_PERIOD_NS       50
`define EVENT_PULSE_CYCLES  ((`EVENT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CNT_WIDTH     8

`endif

// ---- hdl/wake_ready_pkg.sv ----
// Types for the power-on wake-ready controller.
// Assumes the params header is included by users of the constants.
package wake_ready_pkg;
    typedef enum logic [1:0] {
        ST_INIT  = 2'b00,
        ST_READY = 2'b01,
        ST_WAKE  = 2'b10,
        ST_NORM  = 2'b11
    } mode_t;
endpackage

// ---- hdl/edge_fall_detect.sv ----
// Falling-edge detector for an active-low synchronous level.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module edge_fall_detect (
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    input  wire logic level_n_in,
    output logic      fall_out
);
    logic prev_n;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_n <= 1'b1;
        end else begin
            prev_n <= level_n_in;
        end
    end

    assign fall_out = prev_n & ~level_n_in;
endmodule // edge_fall_detect
`default_nettype wire

// ---- hdl/wake_ready_ctrl.sv ----
// Power-on wake-ready controller: standby, wake detection, power event pin.
// Assumes strap and flag inputs are stable at reset release and all inputs
// are synchronous to clk_sys_in.
`include "wake_ready_params.svh"
`timescale 1ns/1ps
`default_nettype none
module wake_ready_ctrl (
    input  wire logic                    clk_sys_in,
    input  wire logic                    rstn_in,
    input  wire logic                    strap_gpio1_in,
    input  wire logic [`FLAG_WIDTH-1:0]  flag_word_in,
    input  wire logic                    phy_mode_in,
    input  wire logic                    magic_packet_in,
    input  wire logic                    sec_link_up_in,
    input  wire logic                    ext_wake_in_n,
    output logic                         power_event_out,
    output logic                         wake_ready_out,
    output logic                         usb_xcvr_en_out,
    output logic                         usb_enum_start_out,
    output logic                         dp_oe_out,
    output logic                         dm_oe_out,
    output logic                         phy_en_out,
    output logic                         autoneg_en_out,
    output logic                         magic_det_en_out
);
    wake_ready_pkg::mode_t mode;
    wake_ready_pkg::mode_t next_mode;
    logic                  event_output_type;
    logic                  event_polarity;
    logic                  event_pin_select;
    logic                  event_indication_sel;
    logic                  wake_enable;
    logic                  ext_fall;
    logic                  link_prev;
    logic                  link_rise;
    logic                  wake_event;
    logic                  event_level;
    logic [`PULSE_CNT_WIDTH-1:0] pulse_cnt;

    edge_fall_detect u_ext_fall (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .level_n_in (ext_wake_in_n),
        .fall_out   (ext_fall)
    );

    // The flag word is captured in the first cycle after release, never in reset.
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            event_output_type    <= 1'b0;
            event_polarity       <= 1'b0;
            event_pin_select     <= 1'b0;
            event_indication_sel <= 1'b0;
            wake_enable          <= 1'b0;
        end else if (mode == wake_ready_pkg::ST_INIT) begin
            event_indication_sel <= flag_word_in[`FLAG_INDICATION_BIT];
            event_output_type    <= flag_word_in[`FLAG_OUT_TYPE_BIT];
            event_polarity       <= flag_word_in[`FLAG_POLARITY_BIT];
            event_pin_select     <= flag_word_in[`FLAG_PIN_SEL_BIT];
            wake_enable          <= strap_gpio1_in
                                    & flag_word_in[`FLAG_PIN_SEL_BIT];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_prev <= 1'b0;
        end else begin
            link_prev <= sec_link_up_in;
        end
    end

    assign link_rise  = sec_link_up_in & ~link_prev;
    assign wake_event = magic_packet_in
                      | (phy_mode_in & link_rise)
                      | ext_fall;

    always_comb begin
        next_mode = mode;
        case (mode)
            wake_ready_pkg::ST_INIT: begin
                if (strap_gpio1_in && flag_word_in[`FLAG_PIN_SEL_BIT]) begin
                    next_mode = wake_ready_pkg::ST_READY;
                end else begin
                    next_mode = wake_ready_pkg::ST_NORM;
                end
            end
            wake_ready_pkg::ST_READY: begin
                if (wake_event) begin
                    next_mode = wake_ready_pkg::ST_WAKE;
                end
            end
            wake_ready_pkg::ST_WAKE: next_mode = wake_ready_pkg::ST_NORM;
            wake_ready_pkg::ST_NORM: next_mode = wake_ready_pkg::ST_NORM;
            default:                 next_mode = wake_ready_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode <= wake_ready_pkg::ST_INIT;
        end else begin
            mode <= next_mode;
        end
    end

    // Static type latches the event until the next reset; pulse type times out.
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            event_level <= 1'b0;
            pulse_cnt   <= '0;
        end else if (mode == wake_ready_pkg::ST_READY && wake_event) begin
            event_level <= 1'b1;
            pulse_cnt   <= `PULSE_CNT_WIDTH'(`EVENT_PULSE_CYCLES);
        end else if (!event_output_type && pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
            if (pulse_cnt == `PULSE_CNT_WIDTH'(1)) begin
                event_level <= 1'b0;
            end
        end
    end

    // The pin is active high whenever wake-ready was enabled at release.
    assign power_event_out    = event_level;
    assign wake_ready_out     = (mode == wake_ready_pkg::ST_READY);
    assign usb_xcvr_en_out    = (mode == wake_ready_pkg::ST_NORM);
    assign usb_enum_start_out = (mode == wake_ready_pkg::ST_NORM);
    assign dp_oe_out          = 1'b0;
    assign dm_oe_out          = 1'b0;
    assign phy_en_out         = 1'b1;
    assign autoneg_en_out     = 1'b1;
    assign magic_det_en_out   = wake_ready_out | usb_xcvr_en_out;

    sequence s_ready_event;
        mode == wake_ready_pkg::ST_READY && wake_event;
    endsequence

    sequence s_wake_then_norm;
        ##1 (mode == wake_ready_pkg::ST_WAKE) ##1 (mode == wake_ready_pkg::ST_NORM);
    endsequence

    AST_EVENT_RAISE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        s_ready_event |=> power_event_out)
        else $error("power event not raised after wakeup");
    AST_LEAVE_READY: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        s_ready_event |-> s_wake_then_norm)
        else $error("wake-ready not left after event");
    AST_STATIC_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (power_event_out && event_output_type) |=> power_event_out)
        else $error("static power event dropped");
    AST_STRAP_HIGH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (mode == wake_ready_pkg::ST_INIT && strap_gpio1_in && flag_word_in[`FLAG_PIN_SEL_BIT])
        |=> wake_ready_out && !usb_xcvr_en_out)
        else $error("wake-ready not entered");
    AST_STRAP_LOW: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (mode == wake_ready_pkg::ST_INIT && !strap_gpio1_in) |=> usb_enum_start_out)
        else $error("normal mode not entered");
    AST_TRISTATE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        wake_ready_out |-> !dp_oe_out && !dm_oe_out && !usb_xcvr_en_out)
        else $error("data lines driven in wake-ready");
    AST_LINK_WAKE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (wake_ready_out && phy_mode_in && $rose(sec_link_up_in)) |=> power_event_out)
        else $error("link-up did not wake");
    AST_EXT_WAKE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (wake_ready_out && $fell(ext_wake_in_n)) |=> power_event_out ##1 usb_enum_start_out)
        else $error("external wake ignored");
    AST_NO_SPURIOUS: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (wake_ready_out && !wake_event) |=> wake_ready_out && !power_event_out)
        else $error("wake-ready left without event");
    AST_READY_PHY: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        wake_ready_out |-> phy_en_out && autoneg_en_out && magic_det_en_out)
        else $error("wake logic off in wake-ready");
    AST_READY_SAMPLED: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (mode == wake_ready_pkg::ST_WAKE) |-> wake_enable)
        else $error("wake-ready reached without sampled strap and flag");
endmodule // wake_ready_ctrl
`default_nettype wire

// ---- bench/wake_far_model.sv ----
// Far-side model: Ethernet receive path, secondary PHY and the external wake pin.
// Assumes fire_in is driven on the rising clock edge and held one cycle.
`timescale 1ns/1ps
`default_nettype none
module wake_far_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic [1:0] fire_in,
    output logic            magic_packet_out,
    output logic            sec_link_up_out,
    output logic            ext_wake_out_n
);
    logic magic  = 1'b0;
    logic link   = 1'b0;
    logic wake_n = 1'b1;
    // Link is a level and stays up, as a real cable would, until reset.
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link <= 1'b0;
        end else begin
            magic  <= (fire_in == 2'h1);
            link   <= link | (fire_in == 2'h2);
            wake_n <= (fire_in != 2'h3);
        end
    end
    assign magic_packet_out = magic;
    assign sec_link_up_out  = link;
    assign ext_wake_out_n   = wake_n;
endmodule // wake_far_model
`default_nettype wire

// ---- bench/tb_wake_ready_ctrl.sv ----
// Testbench for the wake-ready controller: strap and flag setups, each wake source.
// Assumes the far-side model drives the event inputs one cycle after a fire code.
`timescale 1ns/1ps
`default_nettype none
`include "wake_ready_params.svh"
module tb_wake_ready_ctrl;
    logic                   clk_sys_in     = 1'b0;
    logic                   rstn_in        = 1'b0;
    logic                   strap_gpio1_in = 1'b0;
    logic [`FLAG_WIDTH-1:0] flag_word_in   = 16'h0000;
    logic                   phy_mode_in    = 1'b0;
    logic [1:0]             fire           = 2'h0;
    logic magic_packet_in, sec_link_up_in, ext_wake_in_n, power_event_out, wake_ready_out;
    logic usb_xcvr_en_out, usb_enum_start_out, dp_oe_out, dm_oe_out;
    logic phy_en_out, autoneg_en_out, magic_det_en_out;
    int   n_errors = 0;
    int   n_checks = 0;
    int   cnt;
    always #25 clk_sys_in = ~clk_sys_in;
    wake_ready_ctrl dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .strap_gpio1_in(strap_gpio1_in), .flag_word_in(flag_word_in),
        .phy_mode_in(phy_mode_in), .magic_packet_in(magic_packet_in),
        .sec_link_up_in(sec_link_up_in), .ext_wake_in_n(ext_wake_in_n),
        .power_event_out(power_event_out), .wake_ready_out(wake_ready_out),
        .usb_xcvr_en_out(usb_xcvr_en_out), .usb_enum_start_out(usb_enum_start_out),
        .dp_oe_out(dp_oe_out), .dm_oe_out(dm_oe_out), .phy_en_out(phy_en_out),
        .autoneg_en_out(autoneg_en_out), .magic_det_en_out(magic_det_en_out));
    wake_far_model far_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .fire_in(fire),
        .magic_packet_out(magic_packet_in), .sec_link_up_out(sec_link_up_in),
        .ext_wake_out_n(ext_wake_in_n));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask
    task automatic start(input logic s, input logic [15:0] f, input logic p, input int hold);
        @(posedge clk_sys_in);
        rstn_in        <= 1'b0;
        strap_gpio1_in <= s;
        flag_word_in   <= f;
        phy_mode_in    <= p;
        repeat (hold) @(posedge clk_sys_in);
        #1 check(power_event_out, 1'b0, "event in reset");
        @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic check_mode(input logic ready);
        check(wake_ready_out, ready, "mode");
        check(usb_xcvr_en_out, !ready, "transceiver");
        check(usb_enum_start_out, !ready, "enumeration");
        check(dp_oe_out | dm_oe_out, 1'b0, "data lines driven");
        check(phy_en_out & autoneg_en_out & magic_det_en_out, 1'b1, "phy off");
    endtask
    task automatic fire_ev(input logic [1:0] code);
        @(posedge clk_sys_in);
        fire <= code;
        @(posedge clk_sys_in);
        fire <= 2'h0;
    endtask
    task automatic wait_event;
        cnt = 0;
        while (power_event_out !== 1'b1 && cnt < 8) begin
            @(posedge clk_sys_in);
            #1 cnt++;
        end
        check(power_event_out, 1'b1, "no power event");
        if (cnt == 8)
            stop_test();
        @(posedge clk_sys_in);
        #1 check(usb_enum_start_out, 1'b1, "no enumeration");
        check(wake_ready_out, 1'b0, "still wake-ready");
        check(power_event_out, 1'b1, "event high level");
    endtask
    initial begin
        start(1'b1, 16'h7001, 1'b0, 16);
        strap_gpio1_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1 check_mode(1'b1);
        fire_ev(2'h1);
        wait_event();
        repeat (40) @(posedge clk_sys_in);
        #1 check(power_event_out, 1'b1, "static level dropped");
        $display("test static magic packet done");
        for (int code = 2; code < 4; code++) begin
            start(1'b1, 16'h7001, 1'b1, 2);
            check_mode(1'b1);
            fire_ev(code[1:0]);
            wait_event();
        end
        $display("test link and pin wake done");
        start(1'b1, 16'h7001, 1'b0, 2);
        fire_ev(2'h2);
        repeat (4) @(posedge clk_sys_in);
        #1 check(power_event_out, 1'b0, "link woke in MAC mode");
        check(wake_ready_out, 1'b1, "left wake-ready");
        start(1'b1, 16'h3001, 1'b0, 2);
        fire_ev(2'h3);
        wait_event();
        while (power_event_out === 1'b1 && cnt < 100) begin
            @(posedge clk_sys_in);
            #1 cnt++;
        end
        check(cnt == `EVENT_PULSE_CYCLES, 1'b1, "pulse width");
        fire_ev(2'h3);
        repeat (4) @(posedge clk_sys_in);
        #1 check(power_event_out, 1'b0, "second event");
        $display("test pulse type done");
        start(1'b0, 16'h7001, 1'b0, 2);
        strap_gpio1_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1 check_mode(1'b0);
        fire_ev(2'h1);
        repeat (4) @(posedge clk_sys_in);
        #1 check(power_event_out, 1'b0, "event in normal mode");
        $display("test strap low done");
        stop_test();
    end
endmodule // tb_wake_ready_ctrl
`default_nettype wire
